// file: src/icscm_defines.vh
// Constants for the clock source control block
`ifndef ICSCM_DEFINES_VH
`define ICSCM_DEFINES_VH

// Register byte offsets
`define ICSCM_OFF_CTRL1 8'h00
`define ICSCM_OFF_CTRL2 8'h04
`define ICSCM_OFF_TRIM 8'h08
`define ICSCM_OFF_STAT 8'h0C

// Reset values
`define ICSCM_CTRL1_RST 8'h04
`define ICSCM_CTRL2_RST 8'h40
`define ICSCM_TRIM_RST 8'h80

// Control one fields
`define ICSCM_SRC_HI 7
`define ICSCM_SRC_LO 6
`define ICSCM_REFERENCE_DIVIDE_HI 5
`define ICSCM_REFERENCE_DIVIDE_LO 3
`define ICSCM_REFSEL 2
`define ICSCM_IOE 1
`define ICSCM_IST 0

// Control two fields
`define ICSCM_BUS_DIVIDE_HI 7
`define ICSCM_BUS_DIVIDE_LO 6
`define ICSCM_RANGE 5
`define ICSCM_GAIN 4
`define ICSCM_LP 3
`define ICSCM_OSCREQ 2
`define ICSCM_EOE 1
`define ICSCM_EST 0

// Source select codes
`define ICSCM_SRC_LOOP 2'h0
`define ICSCM_SRC_INT 2'h1
`define ICSCM_SRC_EXT 2'h2

// Largest reference divide code and its shift
`define ICSCM_REFERENCE_DIVIDE_TOP 3'h6
`define ICSCM_REFERENCE_DIVIDE_TOP_SHIFT 3'h7

// Loop multiplication factor
`define ICSCM_LOOP_MULT 10'h200

// Edges of a new source needed before a switch
`define ICSCM_SWITCH_EDGES 2'h3

// Oscillator start-up edges
`define ICSCM_OSC_INIT_EDGES 4096

`endif

// file: src/icscm_div.v
// Edge-counting power-of-two clock divider
`timescale 1ns/10ps
module icscm_div #(
  parameter CNT_W = 7
) (
  input wire mclk,
  input wire sys_rst,
  input wire sig_in,
  input wire [2:0] shift,
  output wire sig_out
);

  reg prev_r;
  reg [CNT_W-1:0] cnt_r;
  reg out_r;
  wire rise;

  assign rise = sig_in & ~prev_r;
  assign sig_out = out_r;

  // Count rising edges of the incoming clock
  always @(posedge mclk) begin
    if (sys_rst) begin
      prev_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      prev_r <= sig_in;
      if (rise) begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Shift zero passes the clock, else counter bit shift-1
  always @(posedge mclk) begin
    if (sys_rst) begin
      out_r <= 1'b0;
    end else if (shift == 3'h0) begin
      out_r <= sig_in;
    end else begin
      out_r <= cnt_r[shift - 3'h1];
    end
  end

endmodule

// file: src/icscm_top.v
// Clock source control: registers, mode decode, source switch and dividers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "icscm_defines.vh"
module icscm_top #(
  parameter OSC_INIT_EDGES = `ICSCM_OSC_INIT_EDGES
) (
  input wire mclk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire stop_mode,
  input wire int_ref_clk,
  input wire ext_ref_clk,
  input wire loop_clk,
  output reg loop_enable,
  output reg loop_ref_internal,
  output wire loop_ref_div,
  output wire [9:0] loop_mult,
  output reg int_ref_enable,
  output reg ext_ref_enable,
  output reg internal_reference_out,
  output reg external_reference_out,
  output reg system_clock_out,
  output wire bus_clock_out,
  output reg osc_range,
  output reg osc_gain,
  output reg osc_request,
  output reg [8:0] trim_code
);

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg [7:0] ctrl1_r;
  reg [7:0] ctrl2_r;
  reg [7:0] trim_r;
  reg fine_r;
  reg osc_ready_r;
  reg [1:0] active_r;
  reg [1:0] pend_r;
  reg [1:0] edge_cnt_r;
  reg [12:0] osc_cnt_r;
  reg int_mode_r;
  reg ext_mode_r;
  reg int_prev_r;
  reg ext_prev_r;
  reg loop_prev_r;

  wire [1:0] src_sel;
  wire [2:0] reference_divide;
  wire [1:0] bus_divide;
  wire refsel;
  wire ioe;
  wire ist;
  wire eoe;
  wire est;
  wire lp;
  wire oscreq;

  assign src_sel = ctrl1_r[`ICSCM_SRC_HI:`ICSCM_SRC_LO];
  assign reference_divide = ctrl1_r[`ICSCM_REFERENCE_DIVIDE_HI:`ICSCM_REFERENCE_DIVIDE_LO];
  assign refsel = ctrl1_r[`ICSCM_REFSEL];
  assign ioe = ctrl1_r[`ICSCM_IOE];
  assign ist = ctrl1_r[`ICSCM_IST];
  assign bus_divide = ctrl2_r[`ICSCM_BUS_DIVIDE_HI:`ICSCM_BUS_DIVIDE_LO];
  assign lp = ctrl2_r[`ICSCM_LP];
  assign oscreq = ctrl2_r[`ICSCM_OSCREQ];
  assign eoe = ctrl2_r[`ICSCM_EOE];
  assign est = ctrl2_r[`ICSCM_EST];

  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  wire setup;
  wire wr_en;
  wire hit;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit = (paddr == `ICSCM_OFF_CTRL1) | (paddr == `ICSCM_OFF_CTRL2) |
               (paddr == `ICSCM_OFF_TRIM) | (paddr == `ICSCM_OFF_STAT);
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel & penable & ~hit;

  // Software writes; trim and fine trim have defined reset too
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl1_r <= `ICSCM_CTRL1_RST;
      ctrl2_r <= `ICSCM_CTRL2_RST;
      trim_r <= `ICSCM_TRIM_RST;
      fine_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `ICSCM_OFF_CTRL1) begin
        ctrl1_r <= pwdata[7:0];
      end else if (paddr == `ICSCM_OFF_CTRL2) begin
        ctrl2_r <= pwdata[7:0];
      end else if (paddr == `ICSCM_OFF_TRIM) begin
        trim_r <= pwdata[7:0];
      end else if (paddr == `ICSCM_OFF_STAT) begin
        fine_r <= pwdata[0];
      end
    end
  end

  // Read data captured in the setup cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (paddr == `ICSCM_OFF_CTRL1) begin
        prdata <= {24'h000000, ctrl1_r};
      end else if (paddr == `ICSCM_OFF_CTRL2) begin
        prdata <= {24'h000000, ctrl2_r};
      end else if (paddr == `ICSCM_OFF_TRIM) begin
        prdata <= {24'h000000, trim_r};
      end else if (paddr == `ICSCM_OFF_STAT) begin
        prdata <= {28'h0000000, active_r, osc_ready_r, fine_r};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // --------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------
  reg [1:0] tgt_src;
  reg bypass;
  reg loop_on;

  // reserved select acts as loop output
  // bypass modes and low power variants
  always @* begin
    tgt_src = src_sel;
    if (src_sel == 2'h3) begin
      tgt_src = `ICSCM_SRC_LOOP;
    end
    bypass = (tgt_src != `ICSCM_SRC_LOOP);
    // low power stops the loop in bypass
    loop_on = ~stop_mode & ~(bypass & lp);
  end

  // Remember which reference the mode used before stop
  always @(posedge mclk) begin
    if (sys_rst) begin
      int_mode_r <= 1'b1;
      ext_mode_r <= 1'b0;
    end else if (~stop_mode) begin
      int_mode_r <= refsel;
      ext_mode_r <= ~refsel;
    end
  end

  // Reference enables and loop controls
  always @(posedge mclk) begin
    if (sys_rst) begin
      loop_enable <= 1'b1;
      loop_ref_internal <= 1'b1;
      int_ref_enable <= 1'b1;
      ext_ref_enable <= 1'b0;
    end else begin
      // loop stays on in internal bypass unless lp is set
      // loop stays on in external bypass unless lp is set
      loop_enable <= loop_on;
      loop_ref_internal <= refsel;
      if (stop_mode) begin
        int_ref_enable <= ist & (ioe | int_mode_r);
        ext_ref_enable <= est & (eoe | ext_mode_r);
      end else begin
        int_ref_enable <= ioe | refsel | (tgt_src == `ICSCM_SRC_INT);
        ext_ref_enable <= eoe | ~refsel | (tgt_src == `ICSCM_SRC_EXT);
      end
    end
  end

  // --------------------------------------------------------------
  // Reference outputs and oscillator controls
  // --------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      internal_reference_out <= 1'b0;
      external_reference_out <= 1'b0;
      osc_range <= 1'b0;
      osc_gain <= 1'b0;
      osc_request <= 1'b0;
      trim_code <= {`ICSCM_TRIM_RST, 1'b0};
    end else begin
      // internal output gated by its enable
      internal_reference_out <= int_ref_clk & ioe & int_ref_enable;
      // external output gated by its enable
      external_reference_out <= ext_ref_clk & eoe & ext_ref_enable;
      osc_range <= ctrl2_r[`ICSCM_RANGE];
      osc_gain <= ctrl2_r[`ICSCM_GAIN];
      osc_request <= oscreq;
      // fine trim is the least step
      trim_code <= {trim_r, fine_r};
    end
  end

  // --------------------------------------------------------------
  // Edge detection of the three clock sources
  // --------------------------------------------------------------
  wire int_rise;
  wire ext_rise;
  wire loop_rise;

  assign int_rise = int_ref_clk & ~int_prev_r;
  assign ext_rise = ext_ref_clk & ~ext_prev_r;
  assign loop_rise = loop_clk & ~loop_prev_r;

  always @(posedge mclk) begin
    if (sys_rst) begin
      int_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
      loop_prev_r <= 1'b0;
    end else begin
      int_prev_r <= int_ref_clk;
      ext_prev_r <= ext_ref_clk;
      loop_prev_r <= loop_clk;
    end
  end

  // --------------------------------------------------------------
  // Oscillator ready flag
  // --------------------------------------------------------------
  wire ext_used;
  wire osc_done;

  assign ext_used = eoe | ~refsel | (tgt_src == `ICSCM_SRC_EXT);
  assign osc_done = (osc_cnt_r == OSC_INIT_EDGES[12:0]);

  // set after start-up, cleared by dropping the request or external use
  always @(posedge mclk) begin
    if (sys_rst) begin
      osc_cnt_r <= 13'h0000;
      osc_ready_r <= 1'b0;
    end else if (~oscreq | ~ext_used) begin
      osc_cnt_r <= 13'h0000;
      osc_ready_r <= 1'b0;
    end else if (osc_done) begin
      osc_ready_r <= 1'b1;
    end else if (ext_rise) begin
      osc_cnt_r <= osc_cnt_r + 13'h0001;
    end
  end

  // --------------------------------------------------------------
  // Glitch-safe source switch
  // --------------------------------------------------------------
  reg new_rise;
  reg cur_clk;

  always @* begin
    case (pend_r)
      `ICSCM_SRC_INT: new_rise = int_rise;
      `ICSCM_SRC_EXT: new_rise = ext_rise;
      default: new_rise = loop_rise;
    endcase
    case (active_r)
      `ICSCM_SRC_INT: cur_clk = int_ref_clk;
      `ICSCM_SRC_EXT: cur_clk = ext_ref_clk;
      default: cur_clk = loop_clk;
    endcase
  end

  // count new-clock edges, old source stays meanwhile
  always @(posedge mclk) begin
    if (sys_rst) begin
      active_r <= `ICSCM_SRC_LOOP;
      pend_r <= `ICSCM_SRC_LOOP;
      edge_cnt_r <= 2'h0;
    end else if (tgt_src != pend_r) begin
      pend_r <= tgt_src;
      edge_cnt_r <= 2'h0;
    end else if (pend_r == active_r) begin
      edge_cnt_r <= 2'h0;
    end else if (new_rise) begin
      if (edge_cnt_r == `ICSCM_SWITCH_EDGES - 2'h1) begin
        active_r <= pend_r;
        edge_cnt_r <= 2'h0;
      end else begin
        edge_cnt_r <= edge_cnt_r + 2'h1;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      system_clock_out <= 1'b0;
    end else begin
      system_clock_out <= cur_clk & ~stop_mode;
    end
  end

  // --------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------
  wire loop_ref_src;
  wire [2:0] reference_divide_shift;
  wire sys_src;

  assign loop_ref_src = refsel ? int_ref_clk : ext_ref_clk;
  assign reference_divide_shift = (reference_divide == `ICSCM_REFERENCE_DIVIDE_TOP) ? `ICSCM_REFERENCE_DIVIDE_TOP_SHIFT : reference_divide;
  assign sys_src = cur_clk & ~stop_mode;
  // loop target is 512 times divided reference
  assign loop_mult = `ICSCM_LOOP_MULT;

  // Divided loop reference
  icscm_div #(.CNT_W(7)) u_ref_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig_in(loop_ref_src),
    .shift(reference_divide_shift),
    .sig_out(loop_ref_div)
  );

  icscm_div #(.CNT_W(7)) u_bus_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sig_in(sys_src),
    .shift({1'b0, bus_divide}),
    .sig_out(bus_clock_out)
  );

endmodule

// file: test/icscm_assertions.sv
// Port-level checks for the clock source control block
`timescale 1ns/10ps
module icscm_assertions (
  input wire mclk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire stop_mode,
  input wire ext_ref_clk,
  input wire loop_enable,
  input wire loop_ref_internal,
  input wire [9:0] loop_mult,
  input wire external_reference_out,
  input wire system_clock_out,
  input wire osc_range,
  input wire osc_gain,
  input wire osc_request,
  input wire [8:0] trim_code
);
  // Access phase and address decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  rst_mode_a:
    assert property ($fell(sys_rst) |-> loop_enable && loop_ref_internal && trim_code == 9'h100)
    else $error("reset mode wrong");
  bad_addr_a: // unmapped read refused
    assert property (acc && !pwrite && !mapped |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");
  err_only_a: // error only on unmapped access
    assert property (pslverr |-> acc && !mapped) else $error("stray error");
  mult_fixed_a:
    assert property (loop_mult == 10'h200) else $error("loop factor wrong");
  stop_quiet_a:
    assert property (stop_mode [*2] |-> !system_clock_out && !loop_enable)
    else $error("clock or loop alive in stop");
  ext_gate_a:
    assert property (external_reference_out |-> $past(ext_ref_clk)) else $error("ext out ungated");
  osc_copy_a:
    assert property (wr && paddr == 8'h04 |-> ##2 osc_range == $past(pwdata[5], 2)
      && osc_gain == $past(pwdata[4], 2) && osc_request == $past(pwdata[2], 2))
    else $error("oscillator controls wrong");
  trim_copy_a:
    assert property (wr && paddr == 8'h08 |-> ##2 trim_code[8:1] == $past(pwdata[7:0], 2))
    else $error("coarse trim wrong");
  fine_copy_a:
    assert property (wr && paddr == 8'h0C |-> ##2 trim_code[0] == $past(pwdata[0], 2))
    else $error("fine trim wrong");
  ref_sel_a:
    assert property (wr && paddr == 8'h00 |-> ##2 loop_ref_internal == $past(pwdata[2], 2))
    else $error("loop reference wrong");
endmodule

bind icscm_top icscm_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .prdata(prdata), .stop_mode(stop_mode), .ext_ref_clk(ext_ref_clk),
  .loop_enable(loop_enable), .loop_ref_internal(loop_ref_internal), .loop_mult(loop_mult),
  .external_reference_out(external_reference_out), .system_clock_out(system_clock_out),
  .osc_range(osc_range), .osc_gain(osc_gain), .osc_request(osc_request),
  .trim_code(trim_code));

// file: test/icscm_osc_model.sv
// External crystal or plain clock on the far side of the block
`timescale 1ns/10ps
module icscm_osc_model #(
  parameter HALF = 3,
  parameter START = 20
) (
  input wire mclk,
  input wire osc_request,
  input wire run_en,
  output reg ext_ref_clk
);
  reg [7:0] cnt;
  reg [7:0] warm;
  initial begin
    ext_ref_clk = 1'b0;
    cnt = 8'h00;
    warm = 8'h00;
  end
  // crystal needs start-up, plain clock runs at once
  always @(posedge mclk) begin
    if (!run_en) begin
      ext_ref_clk <= 1'b0;
      cnt <= 8'h00;
      warm <= 8'h00;
    end else if (osc_request && warm < START) begin
      warm <= warm + 8'h01;
    end else if (cnt == HALF - 1) begin
      cnt <= 8'h00;
      ext_ref_clk <= ~ext_ref_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// file: test/internal_clock_source_control_tb.sv
// Self-checking bench for the clock source control block
`timescale 1ns/10ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin err_total++; \
  $display("ERROR %s exp %0h got %0h", n, x, g); end end
module internal_clock_source_control_tb;
  reg mclk, sys_rst, psel, penable, pwrite, stop_mode, int_ref_clk, loop_clk, e, r;
  reg [7:0] paddr, a;
  reg [7:0] cnt = 8'h00;
  reg [31:0] pwdata, q;
  wire pready, pslverr, loop_enable, loop_ref_internal, loop_ref_div, int_ref_enable;
  wire ext_ref_enable, internal_reference_out, external_reference_out, system_clock_out;
  wire bus_clock_out, osc_range, osc_gain, osc_request, ext_ref_clk;
  wire [31:0] prdata;
  wire [9:0] loop_mult;
  wire [8:0] trim_code;
  integer err_total, compares;
  icscm_top #(.OSC_INIT_EDGES(8)) dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .stop_mode(stop_mode), .int_ref_clk(int_ref_clk),
    .ext_ref_clk(ext_ref_clk), .loop_clk(loop_clk), .loop_enable(loop_enable),
    .loop_ref_internal(loop_ref_internal), .loop_ref_div(loop_ref_div),
    .loop_mult(loop_mult), .int_ref_enable(int_ref_enable), .ext_ref_enable(ext_ref_enable),
    .internal_reference_out(internal_reference_out),
    .external_reference_out(external_reference_out), .system_clock_out(system_clock_out),
    .bus_clock_out(bus_clock_out), .osc_range(osc_range), .osc_gain(osc_gain),
    .osc_request(osc_request), .trim_code(trim_code));
  icscm_osc_model #(.HALF(3), .START(20)) osc (.mclk(mclk), .osc_request(osc_request),
    .run_en(ext_ref_enable), .ext_ref_clk(ext_ref_clk));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Slow internal reference and loop clocks
  always @(posedge mclk) begin
    cnt <= cnt + 8'h01;
    int_ref_clk <= cnt[2];
    loop_clk <= cnt[1];
  end
  task conclude;
    begin
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // One APB transfer; read data and error land in q and e
  task apb(input [7:0] ad, input [7:0] d, input w);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      paddr <= ad;
      pwrite <= w;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n == 20) begin
        err_total++;
        conclude;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Poll a status field until it shows v
  task poll(input [7:0] m, input [7:0] v);
    integer n;
    begin
      n = 0;
      apb(8'h0C, 8'h00, 1'b0);
      while ((q[7:0] & m) !== v && n < 300) begin
        n = n + 1;
        apb(8'h0C, 8'h00, 1'b0);
      end
      if (n == 300) begin
        err_total++;
        conclude;
      end
      `CHK("status", v, q[7:0] & m)
    end
  endtask
  // Watch a clock output for 24 cycles; r is 1 if it ever went high
  task seen(input integer s);
    begin
      r = 1'b0;
      repeat (24) begin
        @(posedge mclk);
        r = r | (s == 0 ? internal_reference_out : external_reference_out);
      end
    end
  endtask
  // Cycles between the second and third rise of a divided clock; s=1 bus, s=0 reference
  task period(input s, output integer p);
    integer n, k;
    reg v, last;
    begin
      n = 0;
      k = 0;
      p = 0;
      last = 1'b1;
      while (k < 3 && n < 4000) begin
        @(posedge mclk);
        v = s ? bus_clock_out : loop_ref_div;
        if (v && !last) k = k + 1;
        if (k == 2) p = p + 1;
        last = v;
        n = n + 1;
      end
      if (k < 3) begin
        err_total++;
        conclude;
      end
    end
  endtask
  task t_reset;
    begin
      `CHK("loop_en", 1'b1, loop_enable)
      `CHK("trim_rst", 9'h100, trim_code)
      for (a = 8'h00; a < 8'h10; a = a + 8'h04) begin
        apb(a, 8'h00, 1'b0);
        `CHK("reg_rst", (a == 8'h00) ? 8'h04 : (a == 8'h04) ? 8'h40 : (a == 8'h08) ? 8'h80 : 8'h00, q[7:0])
      end
      apb(8'h10, 8'hFF, 1'b1);
      apb(8'h10, 8'h00, 1'b0);
      `CHK("unmapped", 33'h100000000, {e, q})
      apb(8'h0C, 8'hFF, 1'b1);
      apb(8'h0C, 8'h00, 1'b0);
      `CHK("stat_ro", 8'h01, q[7:0])
      apb(8'h08, 8'h5A, 1'b1);
      apb(8'h08, 8'h00, 1'b0);
      `CHK("trim_code", 9'h0B5, trim_code)
    end
  endtask
  task t_osc;
    begin
      apb(8'h04, 8'h76, 1'b1);
      apb(8'h04, 8'h00, 1'b0);
      `CHK("osc_ctl", 3'h7, {osc_range, osc_gain, osc_request})
      poll(8'h02, 8'h02);
      seen(1);
      `CHK("ext_on", 1'b1, r)
      apb(8'h04, 8'h74, 1'b1);
      poll(8'h02, 8'h00);
      seen(1);
      `CHK("ext_off", 1'b0, r)
    end
  endtask
  task t_switch;
    begin
      apb(8'h00, 8'h80, 1'b1);
      poll(8'h0C, 8'h08);
      `CHK("fbe_loop", 2'h2, {loop_enable, loop_ref_internal})
      apb(8'h04, 8'h7C, 1'b1);
      apb(8'h04, 8'h00, 1'b0);
      `CHK("lp_off", 1'b0, loop_enable)
      apb(8'h00, 8'h46, 1'b1);
      poll(8'h0C, 8'h04);
      apb(8'h04, 8'h74, 1'b1);
      apb(8'h04, 8'h00, 1'b0);
      `CHK("fbi_loop", 1'b1, loop_enable)
      seen(0);
      `CHK("int_on", 1'b1, r)
      apb(8'h00, 8'hC4, 1'b1);
      poll(8'h0C, 8'h00);
    end
  endtask
  task t_stop;
    begin
      apb(8'h00, 8'h07, 1'b1);
      apb(8'h04, 8'h70, 1'b1);
      stop_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("stop_ref", 2'h2, {int_ref_enable, ext_ref_enable})
      `CHK("stop_clk", 2'h0, {system_clock_out, loop_enable})
      apb(8'h00, 8'h04, 1'b1);
      apb(8'h04, 8'h43, 1'b1);
      apb(8'h04, 8'h00, 1'b0);
      `CHK("stop_ref2", 2'h1, {int_ref_enable, ext_ref_enable})
      stop_mode <= 1'b0;
    end
  endtask
  // Divider periods: internal reference is 8 cycles, loop clock 4 cycles
  task t_div;
    integer p;
    begin
      apb(8'h00, 8'h14, 1'b1);
      period(1'b0, p);
      `CHK("ref_div4", 32, p)
      apb(8'h00, 8'h34, 1'b1);
      period(1'b0, p);
      `CHK("ref_div128", 1024, p)
      period(1'b1, p);
      `CHK("bus_div2", 8, p)
      apb(8'h04, 8'hC3, 1'b1);
      period(1'b1, p);
      `CHK("bus_div8", 32, p)
    end
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, stop_mode} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    err_total = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_osc;
    t_switch;
    t_stop;
    t_div;
    conclude;
  end
endmodule
